// ===== hw/relay_device_end.sv
`timescale 1ns/1ps
// Operation
// [R1] one energizes relay, zero de-energizes it
// [R2] point write updates one addressed point
// [R3] point read returns one point state
// [R4] field write sets all sixteen points
// [R5] field read returns sixteen output states
// [R6] writes spaced 24 us, finished within it
// [R7] sixteen points form one strobed field
// [R8] external mode waits for external strobe
// [R9] relay 1 is lsb, relay 16 msb
// [R10] rank 1 holds writes, rank 2 drives
// [R11] reset clears storage, relays de-energized
// [R12] config bit 0 selects external strobe
// [R13] point write modifies only its bit
module relay_device_end
	import relay_out_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        meas_strobe,
	input  wire logic        ext_strobe,
	output logic [15:0]      relay_drive,
	output logic             strobe_wait,
	relay_link_if.dev        link
);

	// ********************************************
	// command handling and two-rank storage
	// ********************************************
	typedef enum logic [1:0] {D_IDLE, D_STORE, D_RESPOND} dev_state_t;

	dev_state_t   state_q, state_d;
	logic [15:0]  rank1_q, rank1_d;
	logic [15:0]  rank2_q, rank2_d;
	logic         ext_mode_q, ext_mode_d;
	logic         pend_q, pend_d;
	logic         armed_q, armed_d;
	logic         ext_prev_q, ext_prev_d;
	logic         rsp_valid_q, rsp_valid_d;
	logic [15:0]  rsp_data_q, rsp_data_d;
	logic         ext_rise;
	logic         transfer;

	function automatic logic [15:0] set_point(input logic [15:0] word, input logic [3:0] idx,
						  input logic val);
		logic [15:0] w;
		w      = word;
		w[idx] = val;
		return w;
	endfunction

	// in external mode a measurement strobe arms, the following external edge transfers
	assign ext_rise = ext_strobe && !ext_prev_q;
	assign transfer = pend_q && (ext_mode_q ? (armed_q && ext_rise) : meas_strobe); // see [R8] see [R12]

	assign link.cmd_ready = (state_q == D_IDLE);
	assign link.rsp_valid = rsp_valid_q;
	assign link.rsp_data  = rsp_data_q;
	assign relay_drive    = rank2_q; // see [R1] see [R9] see [R10]
	assign strobe_wait    = pend_q;

	always_comb begin
		state_d     = state_q;
		rank1_d     = rank1_q;
		rank2_d     = rank2_q;
		ext_mode_d  = ext_mode_q;
		pend_d      = pend_q;
		armed_d     = armed_q;
		ext_prev_d  = ext_strobe;
		rsp_valid_d = 1'b0;
		rsp_data_d  = rsp_data_q;
		if (transfer) begin
			rank2_d = rank1_q; // see [R7] see [R10]
			pend_d  = 1'b0;
			armed_d = 1'b0;
		end else if (pend_q && ext_mode_q && meas_strobe) begin
			armed_d = 1'b1;
		end
		unique case (state_q)
			D_IDLE: begin
				if (link.cmd_valid) begin
					unique case (link.cmd_op)
						CMD_POINT_WRITE: begin
							rank1_d = set_point(rank1_q, link.cmd_point,
									    link.cmd_data[0]); // see [R2] see [R13]
							state_d = D_STORE;
						end
						CMD_FIELD_WRITE: begin
							rank1_d = link.cmd_data; // see [R4]
							state_d = D_STORE;
						end
						CMD_CFG_WRITE: begin
							ext_mode_d = link.cmd_data[CFG_EXT_STROBE_BIT]; // see [R12]
						end
						CMD_POINT_READ: begin
							rsp_data_d = {15'h0000, rank2_q[link.cmd_point]}; // see [R3]
							state_d    = D_RESPOND;
						end
						CMD_FIELD_READ: begin
							rsp_data_d = rank2_q; // see [R5]
							state_d    = D_RESPOND;
						end
						default: state_d = D_IDLE;
					endcase
				end
			end
			D_STORE: begin
				// a write is stored well inside the host spacing window
				pend_d = 1'b1; // see [R6]
				if (link.cmd_meas_strobe && !ext_mode_q) begin
					rank2_d = rank1_q;
					pend_d  = 1'b0;
				end else if (link.cmd_meas_strobe) begin
					// a write with measurement strobe arms the external edge
					armed_d = 1'b1; // see [R8]
				end
				state_d = D_IDLE;
			end
			D_RESPOND: begin
				rsp_valid_d = 1'b1;
				state_d     = D_IDLE;
			end
			default: state_d = D_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= D_IDLE;
			rank1_q     <= FIELD_RESET; // see [R11]
			rank2_q     <= FIELD_RESET; // see [R11]
			ext_mode_q  <= 1'b0;
			pend_q      <= 1'b0;
			armed_q     <= 1'b0;
			ext_prev_q  <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= 16'h0000;
		end else begin
			state_q     <= state_d;
			rank1_q     <= rank1_d;
			rank2_q     <= rank2_d;
			ext_mode_q  <= ext_mode_d;
			pend_q      <= pend_d;
			armed_q     <= armed_d;
			ext_prev_q  <= ext_prev_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q  <= rsp_data_d;
		end
	end

endmodule

// ===== hw/relay_out_pkg.sv
package relay_out_pkg;

	localparam int         POINT_COUNT      = 16;
	localparam int         POINT_IDX_W      = 4;
	localparam logic [15:0] FIELD_RESET     = 16'h0000;
	localparam int         CFG_EXT_STROBE_BIT = 0;
	localparam int         CLK_PERIOD_NS    = 10;
	localparam int         WRITE_INTERVAL_NS = 24000;
	localparam int         WRITE_INTERVAL_CYC = WRITE_INTERVAL_NS / CLK_PERIOD_NS;
	localparam int         STORE_LATENCY_CYC = 2;

	typedef enum logic [2:0] {
		CMD_POINT_WRITE,
		CMD_POINT_READ,
		CMD_FIELD_WRITE,
		CMD_FIELD_READ,
		CMD_CFG_WRITE
	} cmd_t;

endpackage

// ===== hw/relay_link_if.sv
`timescale 1ns/1ps
interface relay_link_if;
	import relay_out_pkg::*;
	logic        cmd_valid;
	logic        cmd_ready;
	cmd_t        cmd_op;
	logic [3:0]  cmd_point;
	logic [15:0] cmd_data;
	logic        cmd_meas_strobe;
	logic        rsp_valid;
	logic [15:0] rsp_data;

	modport dev (
		input  cmd_valid, cmd_op, cmd_point, cmd_data, cmd_meas_strobe,
		output cmd_ready, rsp_valid, rsp_data
	);
	modport host (
		output cmd_valid, cmd_op, cmd_point, cmd_data, cmd_meas_strobe,
		input  cmd_ready, rsp_valid, rsp_data
	);
endinterface

// ===== hw/relay_host_end.sv
`timescale 1ns/1ps
module relay_host_end
	import relay_out_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        req_valid,
	input  cmd_t             req_op,
	input  wire logic [3:0]  req_point,
	input  wire logic [15:0] req_data,
	input  wire logic        req_meas_strobe,
	output logic             req_ready,
	output logic             ans_valid,
	output logic [15:0]      ans_data,
	relay_link_if.host       link
);

	// ********************************************
	// command issue with write pacing
	// ********************************************
	typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT_RSP} host_state_t;

	host_state_t  state_q, state_d;
	cmd_t         op_q, op_d;
	logic [3:0]   point_q, point_d;
	logic [15:0]  data_q, data_d;
	logic         strobe_q, strobe_d;
	logic [15:0]  gap_q, gap_d;
	logic         ans_valid_q, ans_valid_d;
	logic [15:0]  ans_data_q, ans_data_d;

	function automatic logic is_write(input cmd_t op);
		return op == CMD_POINT_WRITE || op == CMD_FIELD_WRITE || op == CMD_CFG_WRITE;
	endfunction

	assign req_ready            = (state_q == H_IDLE) && (gap_q == 16'h0000 || !is_write(req_op));
	assign link.cmd_valid       = (state_q == H_ISSUE);
	assign link.cmd_op          = op_q;
	assign link.cmd_point       = point_q;
	assign link.cmd_data        = data_q;
	assign link.cmd_meas_strobe = strobe_q;
	assign ans_valid            = ans_valid_q;
	assign ans_data             = ans_data_q;

	always_comb begin
		state_d     = state_q;
		op_d        = op_q;
		point_d     = point_q;
		data_d      = data_q;
		strobe_d    = strobe_q;
		gap_d       = (gap_q != 16'h0000) ? gap_q - 16'h0001 : gap_q;
		ans_valid_d = 1'b0;
		ans_data_d  = ans_data_q;
		unique case (state_q)
			H_IDLE: begin
				if (req_valid && req_ready) begin
					op_d     = req_op;
					point_d  = req_point;
					data_d   = req_data;
					strobe_d = req_meas_strobe;
					state_d  = H_ISSUE;
				end
			end
			H_ISSUE: begin
				if (link.cmd_ready) begin
					if (is_write(op_q)) begin
						gap_d   = 16'(WRITE_INTERVAL_CYC - 1); // see [R6]
						state_d = H_IDLE;
					end else begin
						state_d = H_WAIT_RSP;
					end
				end
			end
			H_WAIT_RSP: begin
				if (link.rsp_valid) begin
					ans_valid_d = 1'b1;
					ans_data_d  = link.rsp_data; // see [R3] see [R5]
					state_d     = H_IDLE;
				end
			end
			default: state_d = H_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= H_IDLE;
			op_q        <= CMD_FIELD_READ;
			point_q     <= 4'h0;
			data_q      <= 16'h0000;
			strobe_q    <= 1'b0;
			gap_q       <= 16'h0000;
			ans_valid_q <= 1'b0;
			ans_data_q  <= 16'h0000;
		end else begin
			state_q     <= state_d;
			op_q        <= op_d;
			point_q     <= point_d;
			data_q      <= data_d;
			strobe_q    <= strobe_d;
			gap_q       <= gap_d;
			ans_valid_q <= ans_valid_d;
			ans_data_q  <= ans_data_d;
		end
	end

endmodule

// ===== bench/relay_link_properties.sv
`timescale 1ns/1ps
// ****
// link checks
// ****
module relay_link_properties
	import relay_out_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input cmd_t             cmd_op,
	input wire logic [3:0]  cmd_point,
	input wire logic [15:0] cmd_data,
	input wire logic        cmd_meas_strobe,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_data
);
	logic [11:0] gap_q;
	logic [11:0] gap_d;
	logic        wr_take;
	logic        rd_take;
	assign wr_take = cmd_valid && cmd_ready && (cmd_op inside {CMD_POINT_WRITE,
		CMD_FIELD_WRITE, CMD_CFG_WRITE});
	assign rd_take = cmd_valid && cmd_ready && (cmd_op inside {CMD_POINT_READ, CMD_FIELD_READ});
	// cycles since the last write was taken, saturating
	always_comb begin
		gap_d = gap_q;
		if (wr_take) gap_d = 12'h001;
		else if (gap_q != 12'hfff) gap_d = gap_q + 12'h001;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) gap_q <= 12'hfff;
		else gap_q <= gap_d;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_ready_one_gap: assert property (
		(wr_take || rd_take) && cmd_op != CMD_CFG_WRITE |=> !cmd_ready ##1 cmd_ready)
		else $error("ready gap");
	a_cfg_ready_kept: assert property (
		wr_take && cmd_op == CMD_CFG_WRITE |=> cmd_ready) else $error("config write stalled");
	a_read_answer_two: assert property (
		rd_take |-> ##2 rsp_valid) else $error("read answer late");
	a_rsp_from_read: assert property (
		rsp_valid |-> $past(rd_take, 2)) else $error("answer without read");
	a_rsp_one_cycle: assert property (
		rsp_valid |=> !rsp_valid) else $error("answer too long");
	a_point_upper_zero: assert property (
		rsp_valid && $past(rd_take && cmd_op == CMD_POINT_READ, 2) |-> rsp_data[15:1] == 15'h0000)
		else $error("point answer upper bits");
	a_rsp_data_stands: assert property (
		$changed(rsp_data) |-> $past(rd_take)) else $error("answer data moved");
	a_cmd_held: assert property (
		cmd_valid && !cmd_ready |=> cmd_valid && $stable({cmd_op, cmd_point, cmd_data,
		cmd_meas_strobe})) else $error("command dropped");
	a_write_spacing: assert property (
		wr_take |-> gap_q >= 12'(WRITE_INTERVAL_CYC)) else $error("writes too close");
endmodule

// ===== bench/relay_output_field_16pt_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
// ****
// bench
// ****
module relay_output_field_16pt_tb import relay_out_pkg::*;;
	logic        ref_clk, rst_n, req_valid, req_ms, meas_strobe, ext_strobe, b;
	logic        req_ready, ans_valid, strobe_wait;
	cmd_t        req_op;
	logic [3:0]  req_point, p;
	logic [15:0] req_data, ans_data, relay_drive, model, d;
	int          seed = 89320, checks = 0, miscompares = 0;
	relay_link_if link_if();
	relay_host_end u_relay_host_end(.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_op(req_op), .req_point(req_point), .req_data(req_data),
		.req_meas_strobe(req_ms), .req_ready(req_ready), .ans_valid(ans_valid),
		.ans_data(ans_data), .link(link_if));
	relay_device_end u_relay_device_end(.ref_clk(ref_clk), .rst_n(rst_n),
		.meas_strobe(meas_strobe), .ext_strobe(ext_strobe), .relay_drive(relay_drive),
		.strobe_wait(strobe_wait), .link(link_if));
	relay_link_properties u_relay_link_properties(.ref_clk(ref_clk), .rst_n(rst_n),
		.cmd_valid(link_if.cmd_valid), .cmd_ready(link_if.cmd_ready), .cmd_op(link_if.cmd_op),
		.cmd_point(link_if.cmd_point), .cmd_data(link_if.cmd_data),
		.cmd_meas_strobe(link_if.cmd_meas_strobe), .rsp_valid(link_if.rsp_valid),
		.rsp_data(link_if.rsp_data));
	always #5 ref_clk = ~ref_clk;
	task end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	function automatic logic [15:0] set_bit(logic [15:0] f, logic [3:0] i, logic v);
		set_bit = f;
		set_bit[i] = v;
	endfunction
	// writes are followed by the full update interval
	task automatic req(input cmd_t op, input logic [3:0] pt, input logic [15:0] dt,
		input logic ms);
		int n;
		cyc(1);
		req_valid = 1'b1;
		req_op = op;
		req_point = pt;
		req_data = dt;
		req_ms = ms;
		#1;
		for (n = 0; req_ready !== 1'b1 && n < 3000; n++) cyc(1);
		cyc(1);
		req_valid = 1'b0;
		if (n == 3000) miscompares++;
		if (op inside {CMD_POINT_READ, CMD_FIELD_READ}) begin
			for (n = 0; ans_valid !== 1'b1 && n < 20; n++) cyc(1);
			if (n == 20) miscompares++;
		end else cyc(WRITE_INTERVAL_CYC);
		if (miscompares > 0) end_sim();
	endtask
	task automatic rd_all;
		req(CMD_FIELD_READ, 4'h0, 16'h0000, 1'b0);
		`CHK(ans_data, model)
		`CHK(relay_drive, model)
	endtask
	task automatic strobe_pulse;
		meas_strobe = 1'b1;
		cyc(1);
		meas_strobe = 1'b0;
		cyc(2);
	endtask
	initial begin
		{ref_clk, rst_n, req_valid, req_ms, meas_strobe, ext_strobe} = 6'h00;
		req_op = CMD_FIELD_READ;
		req_point = 4'h0;
		req_data = 16'h0000;
		cyc(20);
		rst_n = 1'b1;
		model = FIELD_RESET;
		`CHK(relay_drive, model)
		`CHK(strobe_wait, 1'b0)
		req(CMD_CFG_WRITE, 4'h0, 16'h0000, 1'b0);
		for (int i = 0; i < 4; i++) begin
			d = (i == 0) ? 16'hffff : (i == 1) ? 16'h8001 : 16'($random(seed));
			req(CMD_FIELD_WRITE, 4'h0, d, 1'b1);
			model = d;
			rd_all();
		end
		for (int i = 0; i < 8; i++) begin
			p = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($random(seed));
			b = 1'($random(seed));
			req(CMD_POINT_WRITE, p, {15'h0000, b}, 1'b1);
			model = set_bit(model, p, b);
			`CHK(relay_drive[p], b)
			req(CMD_POINT_READ, p, 16'h0000, 1'b0);
			`CHK(ans_data, {15'h0000, b})
			rd_all();
		end
		d = ~model;
		req(CMD_FIELD_WRITE, 4'h0, d, 1'b0);
		`CHK(relay_drive, model)
		`CHK(strobe_wait, 1'b1)
		strobe_pulse();
		model = d;
		`CHK(relay_drive, model)
		`CHK(strobe_wait, 1'b0)
		req(CMD_CFG_WRITE, 4'h0, 16'h0001, 1'b0);
		d = ~model;
		req(CMD_FIELD_WRITE, 4'h0, d, 1'b0);
		// an external edge before any measurement strobe moves nothing
		ext_strobe = 1'b1;
		cyc(2);
		ext_strobe = 1'b0;
		`CHK(relay_drive, model)
		strobe_pulse();
		`CHK(relay_drive, model)
		`CHK(strobe_wait, 1'b1)
		ext_strobe = 1'b1;
		cyc(3);
		ext_strobe = 1'b0;
		model = d;
		rd_all();
		`CHK(strobe_wait, 1'b0)
		// write with measurement strobe arms, the external edge alone transfers
		d = ~model;
		req(CMD_FIELD_WRITE, 4'h0, d, 1'b1);
		`CHK(relay_drive, ~d)
		ext_strobe = 1'b1;
		cyc(1);
		ext_strobe = 1'b0;
		cyc(2);
		model = d;
		rd_all();
		// reset in mid-run clears both ranks and the strobe mode
		rst_n = 1'b0;
		cyc(2);
		`CHK(relay_drive, FIELD_RESET)
		rst_n = 1'b1;
		model = FIELD_RESET;
		rd_all();
		`CHK(strobe_wait, 1'b0)
		d = 16'h5a5a;
		req(CMD_FIELD_WRITE, 4'h0, d, 1'b0);
		strobe_pulse();
		model = d;
		`CHK(relay_drive, model)
		end_sim();
	end
endmodule
